// ---- rtl/wdt_top.sv ----
// Watchdog timer reached through two I/O ports of the host bus.
// Assumes asynchronous bus pins; address and data stable around each strobe.
// How it works
// - A write to port 443 hex loads the written byte as count.
// - Each count is one second: code 01 is 1 s, 3F is 63 s.
// - The first load write enables the watchdog and starts the countdown.
// - Each later load write restarts the countdown from the new code.
// - A read of port 43 hex disables the watchdog until reloaded.
module wdt_top
  import wdt_pkg::*;
#(
  parameter int SEC_CYCLES = WDT_SEC_CYCLES
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [15:0] io_addr,
  input  wire logic [7:0]  io_wdata,
  input  wire logic        io_wr_n,
  input  wire logic        io_rd_n,
  output logic             wdt_active,
  output logic             sys_reset_req
);

  wdt_io_t     io_s1;
  wdt_io_t     io_s2;
  wdt_io_t     io_s3;
  logic        load_evt;
  logic        dis_evt;
  logic [7:0]  count;
  logic        sec_tick;

  // ==========================================================
  // Pin synchronisers; edges are taken only from stages 2 and 3
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      io_s1 <= WDT_IO_IDLE;
      io_s2 <= WDT_IO_IDLE;
      io_s3 <= WDT_IO_IDLE;
    end else begin
      io_s1 <= '{addr: io_addr, data: io_wdata, wr_n: io_wr_n, rd_n: io_rd_n};
      io_s2 <= io_s1;
      io_s3 <= io_s2;
    end
  end

  // ==========================================================
  // Port decode on the falling strobe edge
  always_comb begin
    load_evt = io_s3.wr_n && !io_s2.wr_n && (io_s2.addr == WDT_LOAD_PORT);
    dis_evt  = io_s3.rd_n && !io_s2.rd_n && (io_s2.addr == WDT_DISABLE_PORT);
  end

  // ==========================================================
  // Seconds divider, restarted by each load
  wdt_sec_tick #(
    .TICK_CYCLES (SEC_CYCLES)
  ) wdt_sec_tick_inst (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .restart (load_evt),
    .run     (wdt_active),
    .tick    (sec_tick)
  );

  // ==========================================================
  // Enable: a load wins over a disable in the same cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wdt_active <= 1'b0;
    end else if (load_evt) begin
      wdt_active <= 1'b1;
    end else if (dis_evt) begin
      wdt_active <= 1'b0;
    end else if (sec_tick && count <= WDT_CODE_MIN) begin
      wdt_active <= 1'b0;
    end
  end

  // ==========================================================
  // Countdown in whole seconds; undefined code 00 expires at first tick
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count <= WDT_COUNT_RST;
    end else if (load_evt) begin
      count <= io_s2.data;
    end else if (wdt_active && sec_tick && count > 8'h00) begin
      count <= count - 8'h01;
    end
  end

  // ==========================================================
  // Reset request holds until the host reloads or disables
  // An expiry tick wins over a disable read in the same cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sys_reset_req <= 1'b0;
    end else if (wdt_active && sec_tick && count <= WDT_CODE_MIN && !load_evt) begin
      sys_reset_req <= 1'b1;
    end else if (load_evt || dis_evt) begin
      sys_reset_req <= 1'b0;
    end
  end

  // ==========================================================
  // Checks
  property p_load_takes_byte;
    @(posedge clk_sys) disable iff (!rst_n)
    load_evt |=> (count == $past(io_s2.data)) && wdt_active;
  endproperty
  a_load_takes_byte: assert property (p_load_takes_byte)
    else $error("load write did not set count and enable");

  property p_one_per_second;
    @(posedge clk_sys) disable iff (!rst_n)
    (wdt_active && sec_tick && count > WDT_CODE_MIN && !load_evt)
      |=> count == $past(count) - 8'h01;
  endproperty
  a_one_per_second: assert property (p_one_per_second)
    else $error("countdown did not drop by one per second");

  property p_no_drop_between_ticks;
    @(posedge clk_sys) disable iff (!rst_n)
    (!sec_tick && !load_evt) |=> $stable(count);
  endproperty
  a_no_drop_between_ticks: assert property (p_no_drop_between_ticks)
    else $error("count changed without a second tick");

  property p_reload_restarts;
    @(posedge clk_sys) disable iff (!rst_n)
    (load_evt && wdt_active) |=> !sec_tick ##0 (count == $past(io_s2.data));
  endproperty
  a_reload_restarts: assert property (p_reload_restarts)
    else $error("refresh did not restart the countdown");

  property p_disable_stops;
    @(posedge clk_sys) disable iff (!rst_n)
    (dis_evt && !load_evt && !(wdt_active && sec_tick && count <= WDT_CODE_MIN))
      |=> !wdt_active && !sys_reset_req;
  endproperty
  a_disable_stops: assert property (p_disable_stops)
    else $error("disable read did not stop the watchdog");

  property p_stays_off;
    @(posedge clk_sys) disable iff (!rst_n)
    (!wdt_active && !load_evt) |=> !wdt_active && $stable(count);
  endproperty
  a_stays_off: assert property (p_stays_off)
    else $error("watchdog restarted without a load write");

  property p_expiry_resets;
    @(posedge clk_sys) disable iff (!rst_n)
    (wdt_active && sec_tick && count <= WDT_CODE_MIN && !load_evt)
      |=> sys_reset_req && !wdt_active;
  endproperty
  a_expiry_resets: assert property (p_expiry_resets)
    else $error("expiry did not raise reset request");

  property p_req_cause;
    @(posedge clk_sys) disable iff (!rst_n)
    $rose(sys_reset_req) |-> $past(wdt_active && sec_tick);
  endproperty
  a_req_cause: assert property (p_req_cause)
    else $error("reset request without expiry");

  // ==========================================================
  // Cycles since the last load or tick; a load starts from zero
  // because the divider restarts on the same edge that samples the load event
  logic [31:0] tick_gap;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tick_gap <= 32'h0000_0000;
    end else if (load_evt) begin
      tick_gap <= 32'h0000_0000;
    end else if (sec_tick) begin
      tick_gap <= 32'h0000_0001;
    end else if (tick_gap != 32'hffff_ffff) begin
      tick_gap <= tick_gap + 32'h0000_0001;
    end
  end

  property p_tick_spacing;
    @(posedge clk_sys) disable iff (!rst_n)
    sec_tick |-> tick_gap == 32'(SEC_CYCLES);
  endproperty
  a_tick_spacing: assert property (p_tick_spacing)
    else $error("second tick not one second after load or tick");

  property p_tick_single;
    @(posedge clk_sys) disable iff (!rst_n)
    sec_tick |=> !sec_tick;
  endproperty
  a_tick_single: assert property (p_tick_single)
    else $error("second tick lasted more than one cycle");

  property p_tick_needs_run;
    @(posedge clk_sys) disable iff (!rst_n)
    sec_tick |-> $past(wdt_active);
  endproperty
  a_tick_needs_run: assert property (p_tick_needs_run)
    else $error("second tick while the watchdog was off");

  property p_enable_by_load;
    @(posedge clk_sys) disable iff (!rst_n)
    $rose(wdt_active) |-> $past(load_evt);
  endproperty
  a_enable_by_load: assert property (p_enable_by_load)
    else $error("watchdog enabled without a load write");

  property p_req_holds;
    @(posedge clk_sys) disable iff (!rst_n)
    (sys_reset_req && !load_evt && !dis_evt) |=> sys_reset_req;
  endproperty
  a_req_holds: assert property (p_req_holds)
    else $error("reset request dropped on its own");

  property p_load_clears_req;
    @(posedge clk_sys) disable iff (!rst_n)
    load_evt |=> !sys_reset_req;
  endproperty
  a_load_clears_req: assert property (p_load_clears_req)
    else $error("load write left the reset request set");

endmodule

// ---- inc/wdt_pkg.sv ----
// Package of constants and carrier types for the I/O port watchdog.
// Assumes a single 40 MHz system clock and an ISA-style I/O cycle.
package wdt_pkg;

  // ==========================================================
  // I/O port map
  localparam logic [15:0] WDT_LOAD_PORT    = 16'h0443;
  localparam logic [15:0] WDT_DISABLE_PORT = 16'h0043;

  // ==========================================================
  // Timeout code range and timing
  localparam logic [7:0] WDT_CODE_MIN  = 8'h01;
  localparam logic [7:0] WDT_CODE_MAX  = 8'h3f;
  localparam int         WDT_CLK_HZ    = 40000000;
  localparam int         WDT_SECOND_MS = 1000;
  localparam int         WDT_SEC_CYCLES = WDT_CLK_HZ / 1000 * WDT_SECOND_MS;

  // ==========================================================
  // Reset values
  localparam logic [7:0] WDT_COUNT_RST = 8'h00;

  // ==========================================================
  // Sampled I/O bus lines, strobes active low
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
    logic        wr_n;
    logic        rd_n;
  } wdt_io_t;

  localparam wdt_io_t WDT_IO_IDLE = '{addr: 16'h0000, data: 8'h00, wr_n: 1'b1, rd_n: 1'b1};

endpackage

// ---- rtl/wdt_sec_tick.sv ----
// One-second tick divider for the watchdog countdown.
// Assumes restart and run come from logic on clk_sys.
module wdt_sec_tick
  import wdt_pkg::*;
#(
  parameter int TICK_CYCLES = WDT_SEC_CYCLES
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic restart,
  input  wire logic run,
  output logic      tick
);

  logic [31:0] div_cnt;

  // ==========================================================
  // Divider: restart gives a full second before the next tick
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 32'h0000_0000;
      tick    <= 1'b0;
    end else if (restart || !run) begin
      div_cnt <= 32'h0000_0000;
      tick    <= 1'b0;
    end else if (div_cnt == 32'(TICK_CYCLES - 1)) begin
      div_cnt <= 32'h0000_0000;
      tick    <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 32'h0000_0001;
      tick    <= 1'b0;
    end
  end

endmodule

// ---- verif/wdt_top_test.sv ----
// Self-checking bench for the I/O port watchdog, with a short second.
// Assumes wdt_top and wdt_pkg are compiled first.
module wdt_top_test
  import wdt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Clock, reset and bus
  localparam int SC = 10;
  logic    clk_sys = 1'b0;
  logic    rst_n   = 1'b0;
  wdt_io_t bus     = WDT_IO_IDLE;
  logic    wdt_active;
  logic    sys_reset_req;
  int      error_cnt   = 0;
  int      comparisons = 0;

  always #12.5 clk_sys = ~clk_sys;

  wdt_top #(.SEC_CYCLES(SC)) wdt_top_inst (
    .clk_sys      (clk_sys),
    .rst_n        (rst_n),
    .io_addr      (bus.addr),
    .io_wdata     (bus.data),
    .io_wr_n      (bus.wr_n),
    .io_rd_n      (bus.rd_n),
    .wdt_active   (wdt_active),
    .sys_reset_req(sys_reset_req)
  );

  // ==========================================================
  // Shared tasks
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic chk(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask

  // Strobe low 4 cycles then high 4; returns 8 edges after the falling edge
  task automatic io_cycle(input logic [15:0] a, input logic [7:0] d, input logic wr);
    bus.addr = a;
    bus.data = d;
    step(1);
    if (wr) bus.wr_n = 1'b0;
    else bus.rd_n = 1'b0;
    step(4);
    bus.wr_n = 1'b1;
    bus.rd_n = 1'b1;
    step(4);
  endtask

  task automatic expect_expiry(input int n);
    int c;
    c = 8;
    while (sys_reset_req !== 1'b1 && c < n * SC + 20) begin
      step(1);
      c++;
    end
    chk(c >= n * SC + 3 && c <= n * SC + 6, "expiry time wrong");
    chk(wdt_active === 1'b0, "still active after expiry");
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_load_expire();
    chk(wdt_active === 1'b0 && sys_reset_req === 1'b0, "bad reset state");
    io_cycle(WDT_LOAD_PORT, 8'h02, 1'b1);
    chk(wdt_active === 1'b1, "load did not enable");
    expect_expiry(2);
    step(20);
    chk(sys_reset_req === 1'b1, "reset request dropped");
    io_cycle(WDT_LOAD_PORT, WDT_CODE_MAX, 1'b1);
    chk(wdt_active === 1'b1 && sys_reset_req === 1'b0, "reload failed");
    expect_expiry(63);
    io_cycle(WDT_LOAD_PORT, WDT_CODE_MIN, 1'b1);
    expect_expiry(1);
    $display("t_load_expire done");
  endtask

  task automatic t_refresh();
    io_cycle(WDT_LOAD_PORT, 8'h03, 1'b1);
    step(15);
    io_cycle(WDT_LOAD_PORT, 8'h02, 1'b1);
    expect_expiry(2);
    $display("t_refresh done");
  endtask

  task automatic t_disable();
    io_cycle(WDT_DISABLE_PORT, 8'h00, 1'b0);
    chk(sys_reset_req === 1'b0, "disable left reset request");
    io_cycle(WDT_LOAD_PORT, 8'h05, 1'b1);
    chk(wdt_active === 1'b1, "load before disable ignored");
    step(10);
    io_cycle(WDT_DISABLE_PORT, 8'h00, 1'b0);
    chk(wdt_active === 1'b0, "disable read ignored");
    step(70);
    chk(sys_reset_req === 1'b0, "expired while disabled");
    $display("t_disable done");
  endtask

  task automatic t_other_ports();
    io_cycle(16'h0444, 8'h02, 1'b1);
    io_cycle(WDT_DISABLE_PORT, 8'h02, 1'b1);
    io_cycle(WDT_LOAD_PORT, 8'h00, 1'b0);
    chk(wdt_active === 1'b0, "foreign access enabled");
    step(40);
    chk(sys_reset_req === 1'b0, "foreign access expired");
    $display("t_other_ports done");
  endtask

  // Reset in mid-run clears a held request and a running countdown
  task automatic t_mid_reset();
    io_cycle(WDT_LOAD_PORT, WDT_CODE_MIN, 1'b1);
    expect_expiry(1);
    rst_n = 1'b0;
    step(1);
    chk(wdt_active === 1'b0 && sys_reset_req === 1'b0, "reset left request or enable");
    rst_n = 1'b1;
    step(3);
    io_cycle(WDT_LOAD_PORT, 8'h05, 1'b1);
    chk(wdt_active === 1'b1, "load after reset ignored");
    step(20);
    rst_n = 1'b0;
    step(1);
    rst_n = 1'b1;
    step(80);
    chk(wdt_active === 1'b0 && sys_reset_req === 1'b0, "countdown survived reset");
    $display("t_mid_reset done");
  endtask

  // ==========================================================
  // Sequence, watchdog and verdict
  task automatic close_out();
    $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    step(3);
    rst_n = 1'b1;
    step(4);
    t_load_expire();
    t_refresh();
    t_disable();
    t_other_ports();
    t_mid_reset();
    close_out();
  end

  initial begin
    repeat (5000) @(posedge clk_sys);
    error_cnt++;
    $display("Error at %0t: watchdog timeout", $time);
    close_out();
  end
endmodule
